// File: verilog/rfsm_top.v
// Contract
// - Transparent mode starts on chip-select rising edge after its command.
// - Transparent mode lasts only while chip-select stays high.
// - In transparent mode MOSI high turns the modulator on.
// - In transparent mode receiver enable follows SCLK.
// - In transparent mode the AM channel output drives MISO.
// - In transparent mode the PM channel output drives the interrupt pin.
// - With one channel selected it goes to MISO; interrupt pin held low.
// - Any serial command ends transparent mode; controller re-issues it.
// - In transparent mode field-detect enable routes the field detector to the interrupt pin.
// - Field detect with all operation bits clear: low-power target, field-on event.
// - First stream bit sits in the FIFO byte LSB.
// - Sub-carrier stream supports fc/64 to fc/8.
// - Sub-carrier reporting period is two to eight sub-carrier periods.
// - First period with sub-carrier raises start of receive and writes first bit.
// - Sub-carrier bit is 1 with sub-carrier present, else 0.
// - Sub-carrier receive ends after more than eight empty periods.
// - Sub-carrier scf 01 is fc/32, scp 10 is four periods.
// - Phase stream supports fc/16 to fc/4, one to eight periods.
// - Phase bit 0 for initial phase, 1 inverted; ends at first empty period.
// - Phase scf 01 is fc/8, scp 01 is two periods.
// - Stream transmit holds each FIFO bit one bit period, 1 modulated.
`include "rfsm_defines.vh"
module rfsm_top (
    // Clock and reset
    input wire clk_i,
    input wire srst_i,
    // One pulse per carrier cycle, same clock domain
    input wire fc_tick_i,
    // Serial-port pins
    input wire ss_i,
    input wire mosi_i,
    input wire sclk_i,
    output reg miso_o,
    output reg miso_oe_n_o,
    output reg irq_pin_o,
    // Serial-port command decoder events
    input wire cmd_transparent_i,
    input wire cmd_any_i,
    input wire cmd_transmit_i,
    // Configuration
    input wire rx_am_en_i,
    input wire rx_pm_en_i,
    input wire external_field_detect_enable_i,
    input wire [7:0] op_ctrl_i,
    input wire stream_en_i,
    input wire stream_kind_i,
    input wire [1:0] scf_i,
    input wire [2:0] scp_i,
    input wire [2:0] stx_i,
    // Analog front end
    input wire am_sub_i,
    input wire pm_sub_i,
    input wire ext_field_i,
    output reg mod_on_o,
    output reg rx_on_o,
    // Receive FIFO side
    output reg [7:0] rx_byte_o,
    output reg rx_byte_valid_o,
    output reg [3:0] rx_byte_bits_o,
    // Transmit FIFO side
    input wire [7:0] tx_byte_i,
    input wire tx_avail_i,
    output reg tx_pop_o,
    // Status and events
    output reg transparent_o,
    output reg low_power_target_o,
    output reg field_on_evt_o,
    output reg rx_start_evt_o,
    output reg rx_end_evt_o,
    output reg tx_busy_o,
    output reg tx_end_evt_o
);
    localparam ST_IDLE = 2'h0;
    localparam ST_ARMED = 2'h1;
    localparam ST_TRANS = 2'h2;
    localparam RX_WAIT = 2'h0;
    localparam RX_RUN = 2'h1;

    wire [5:0] sync_w;
    wire ss_s;
    wire mosi_s;
    wire sclk_s;
    wire am_s;
    wire pm_s;
    wire ext_s;
    reg [1:0] st_reg;
    reg [1:0] st_next;
    reg ss_d_reg;
    reg ext_d_reg;
    reg [1:0] rx_st_reg;
    reg [7:0] shift_reg;
    reg [3:0] nbits_reg;
    reg [3:0] empty_reg;
    reg init_phase_reg;
    reg tx_mod_reg;
    reg [7:0] tx_shift_reg;
    reg [3:0] tx_left_reg;
    reg [7:0] tx_tick_reg;
    reg [7:0] div_w;
    reg [3:0] per_w;
    wire det_done;
    wire det_present;
    wire det_phase;
    wire rx_run;
    wire ss_rise;
    wire [7:0] tx_len_w;

    // Pins and analog levels cross into the clock domain first
    rfsm_sync #(.WIDTH(6)) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i({ext_field_i, pm_sub_i, am_sub_i, sclk_i, mosi_i, ss_i}),
        .sync_o(sync_w)
    );
    assign ss_s = sync_w[0];
    assign mosi_s = sync_w[1];
    assign sclk_s = sync_w[2];
    assign am_s = sync_w[3];
    assign pm_s = sync_w[4];
    assign ext_s = sync_w[5];
    assign ss_rise = ss_s & ~ss_d_reg;

    // Divider and period count per stream kind
    always @* begin
        if (stream_kind_i == `RFSM_STREAM_SC) begin
            div_w = `RFSM_SC_DIV_BASE >> scf_i;
            per_w = {1'b0, scp_i} + `RFSM_SC_PER_OFS;
            if (per_w > 4'h8) begin
                per_w = 4'h8;
            end
        end else begin
            div_w = `RFSM_PS_DIV_BASE >> scf_i;
            if (scf_i == 2'h3) begin
                div_w = 8'h04;
            end
            per_w = {1'b0, scp_i} + `RFSM_PS_PER_OFS;
        end
    end

    assign rx_run = stream_en_i && (st_reg != ST_TRANS) && !tx_busy_o;

    rfsm_period_det u_det (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .run_i(rx_run),
        .fc_tick_i(fc_tick_i),
        .sig_i(stream_kind_i == `RFSM_STREAM_SC ? am_s : pm_s),
        .div_i(div_w),
        .periods_i(per_w),
        .done_o(det_done),
        .present_o(det_present),
        .phase_o(det_phase)
    );

    // Transparent mode sequencing
    always @* begin
        st_next = st_reg;
        case (st_reg)
            ST_IDLE: begin
                if (cmd_transparent_i) begin
                    st_next = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (ss_rise) begin
                    st_next = ST_TRANS;
                end else if (cmd_any_i && !cmd_transparent_i) begin
                    st_next = ST_IDLE;
                end
            end
            ST_TRANS: begin
                if (!ss_s || cmd_any_i) begin
                    st_next = cmd_transparent_i ? ST_ARMED : ST_IDLE;
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            st_reg <= ST_IDLE;
            ss_d_reg <= 1'b0;
            ext_d_reg <= 1'b0;
            transparent_o <= 1'b0;
            mod_on_o <= 1'b0;
            rx_on_o <= 1'b0;
            miso_o <= 1'b0;
            miso_oe_n_o <= 1'b1;
            irq_pin_o <= 1'b0;
            low_power_target_o <= 1'b0;
            field_on_evt_o <= 1'b0;
        end else begin
            st_reg <= st_next;
            ss_d_reg <= ss_s;
            ext_d_reg <= ext_s;
            transparent_o <= (st_next == ST_TRANS);
            low_power_target_o <= external_field_detect_enable_i && (op_ctrl_i == 8'h00);
            field_on_evt_o <= external_field_detect_enable_i && (op_ctrl_i == 8'h00) && ext_s && !ext_d_reg;
            if (st_next == ST_TRANS) begin
                mod_on_o <= mosi_s;
                rx_on_o <= sclk_s;
                miso_oe_n_o <= 1'b0;
                if (rx_am_en_i && rx_pm_en_i) begin
                    miso_o <= am_s;
                    irq_pin_o <= pm_s;
                end else begin
                    miso_o <= rx_am_en_i ? am_s : (rx_pm_en_i ? pm_s : 1'b0);
                    irq_pin_o <= 1'b0;
                end
                if (external_field_detect_enable_i) begin
                    irq_pin_o <= ext_s;
                end
            end else begin
                mod_on_o <= tx_mod_reg;
                rx_on_o <= stream_en_i;
                miso_oe_n_o <= 1'b1;
                miso_o <= 1'b0;
                irq_pin_o <= 1'b0;
            end
        end
    end

    // Stream receive: reporting periods become FIFO bits
    always @(posedge clk_i) begin
        if (srst_i || !rx_run) begin
            rx_st_reg <= RX_WAIT;
            shift_reg <= 8'h00;
            nbits_reg <= 4'h0;
            empty_reg <= 4'h0;
            init_phase_reg <= 1'b0;
            rx_byte_o <= 8'h00;
            rx_byte_valid_o <= 1'b0;
            rx_byte_bits_o <= 4'h0;
            rx_start_evt_o <= 1'b0;
            rx_end_evt_o <= 1'b0;
        end else begin
            rx_byte_valid_o <= 1'b0;
            rx_start_evt_o <= 1'b0;
            rx_end_evt_o <= 1'b0;
            if (det_done) begin
                case (rx_st_reg)
                    RX_WAIT: begin
                        if (det_present) begin
                            rx_st_reg <= RX_RUN;
                            rx_start_evt_o <= 1'b1;
                            init_phase_reg <= det_phase;
                            // First bit: 1 for sub-carrier, 0 for the reference phase
                            shift_reg <= {7'h00, stream_kind_i == `RFSM_STREAM_SC};
                            nbits_reg <= 4'h1;
                            empty_reg <= 4'h0;
                        end
                    end
                    RX_RUN: begin
                        if (stream_kind_i == `RFSM_STREAM_PS && !det_present) begin
                            rx_st_reg <= RX_WAIT;
                            rx_end_evt_o <= 1'b1;
                            rx_byte_valid_o <= (nbits_reg != 4'h0);
                            rx_byte_o <= shift_reg;
                            rx_byte_bits_o <= nbits_reg;
                            nbits_reg <= 4'h0;
                            shift_reg <= 8'h00;
                        end else if (stream_kind_i == `RFSM_STREAM_SC && !det_present &&
                                     empty_reg == `RFSM_SC_END_PERIODS) begin
                            rx_st_reg <= RX_WAIT;
                            rx_end_evt_o <= 1'b1;
                            rx_byte_valid_o <= (nbits_reg != 4'h0);
                            rx_byte_o <= shift_reg;
                            rx_byte_bits_o <= nbits_reg;
                            nbits_reg <= 4'h0;
                            shift_reg <= 8'h00;
                        end else begin
                            empty_reg <= det_present ? 4'h0 : empty_reg + 4'h1;
                            if (nbits_reg == 4'h8) begin
                                rx_byte_valid_o <= 1'b1;
                                rx_byte_o <= shift_reg;
                                rx_byte_bits_o <= 4'h8;
                                nbits_reg <= 4'h1;
                                shift_reg <= 8'h00;
                                if (stream_kind_i == `RFSM_STREAM_SC) begin
                                    shift_reg[0] <= det_present;
                                end else begin
                                    shift_reg[0] <= det_phase ^ init_phase_reg;
                                end
                            end else begin
                                nbits_reg <= nbits_reg + 4'h1;
                                if (stream_kind_i == `RFSM_STREAM_SC) begin
                                    shift_reg[nbits_reg[2:0]] <= det_present;
                                end else begin
                                    shift_reg[nbits_reg[2:0]] <= det_phase ^ init_phase_reg;
                                end
                            end
                        end
                    end
                    default: begin
                        rx_st_reg <= RX_WAIT;
                    end
                endcase
            end
        end
    end

    // Stream transmit: each FIFO bit keys the modulator for one bit period
    assign tx_len_w = `RFSM_TX_BIT_BASE >> stx_i;

    always @(posedge clk_i) begin
        if (srst_i || !stream_en_i) begin
            tx_busy_o <= 1'b0;
            tx_mod_reg <= 1'b0;
            tx_shift_reg <= 8'h00;
            tx_left_reg <= 4'h0;
            tx_tick_reg <= 8'h00;
            tx_pop_o <= 1'b0;
            tx_end_evt_o <= 1'b0;
        end else begin
            tx_pop_o <= 1'b0;
            tx_end_evt_o <= 1'b0;
            if (!tx_busy_o) begin
                tx_mod_reg <= 1'b0;
                if (cmd_transmit_i) begin
                    tx_busy_o <= 1'b1;
                    tx_left_reg <= 4'h0;
                    tx_tick_reg <= 8'h00;
                end
            end else if (tx_left_reg == 4'h0 && !tx_pop_o) begin
                if (tx_avail_i) begin
                    tx_pop_o <= 1'b1;
                    tx_shift_reg <= tx_byte_i >> 1;
                    tx_mod_reg <= tx_byte_i[0];
                    tx_left_reg <= 4'h8;
                    tx_tick_reg <= 8'h00;
                end else begin
                    tx_busy_o <= 1'b0;
                    tx_mod_reg <= 1'b0;
                    tx_end_evt_o <= 1'b1;
                end
            end else if (fc_tick_i && tx_left_reg != 4'h0) begin
                if (tx_tick_reg + 8'h01 >= tx_len_w) begin
                    tx_tick_reg <= 8'h00;
                    tx_left_reg <= tx_left_reg - 4'h1;
                    if (tx_left_reg != 4'h1) begin
                        tx_mod_reg <= tx_shift_reg[0];
                        tx_shift_reg <= tx_shift_reg >> 1;
                    end
                end else begin
                    tx_tick_reg <= tx_tick_reg + 8'h01;
                end
            end
        end
    end
endmodule

// File: verilog/rfsm_defines.vh
`ifndef RFSM_DEFINES_VH
`define RFSM_DEFINES_VH
// Sub-carrier stream: divider fc/64 at scf 00, period count is scp + 2, at most 8
`define RFSM_SC_DIV_BASE 8'h40
`define RFSM_SC_PER_OFS 4'h2
// Phase-shift stream: divider fc/16 at scf 00, period count is scp + 1
`define RFSM_PS_DIV_BASE 8'h10
`define RFSM_PS_PER_OFS 4'h1
// Empty reporting periods tolerated before end of receive
`define RFSM_SC_END_PERIODS 4'h8
// Transmit bit period at stx 000, in carrier cycles
`define RFSM_TX_BIT_BASE 8'h80
// Stream kinds
`define RFSM_STREAM_SC 1'b0
`define RFSM_STREAM_PS 1'b1
`endif

// File: verilog/rfsm_sync.v
module rfsm_sync #(
    parameter WIDTH = 1
) (
    input wire clk_i,
    input wire srst_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always @(posedge clk_i) begin
                if (srst_i) begin
                    meta_reg[g] <= 1'b0;
                    sync_reg[g] <= 1'b0;
                end else begin
                    meta_reg[g] <= async_i[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate
    assign sync_o = sync_reg;
endmodule

// File: verilog/rfsm_period_det.v
// Times one reporting period in carrier ticks and judges sub-carrier presence
module rfsm_period_det (
    input wire clk_i,
    input wire srst_i,
    input wire run_i,
    input wire fc_tick_i,
    input wire sig_i,
    input wire [7:0] div_i,
    input wire [3:0] periods_i,
    output reg done_o,
    output reg present_o,
    output reg phase_o
);
    reg [11:0] tick_reg;
    reg [4:0] edge_reg;
    reg sig_d_reg;
    reg phase_reg;
    wire [11:0] len_w;
    wire [4:0] edges_w;
    assign len_w = div_i * periods_i;
    assign edges_w = edge_reg + {4'h0, sig_i & ~sig_d_reg};
    always @(posedge clk_i) begin
        if (srst_i || !run_i) begin
            tick_reg <= 12'h000;
            edge_reg <= 5'h00;
            sig_d_reg <= 1'b0;
            phase_reg <= 1'b0;
            done_o <= 1'b0;
            present_o <= 1'b0;
            phase_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (fc_tick_i) begin
                sig_d_reg <= sig_i;
                if (tick_reg == 12'h000) begin
                    phase_reg <= sig_i;
                end
                if (tick_reg + 12'h001 >= len_w) begin
                    tick_reg <= 12'h000;
                    edge_reg <= 5'h00;
                    done_o <= 1'b1;
                    // At least half of the expected sub-carrier edges
                    present_o <= ({edges_w, 1'b0} >= {2'h0, periods_i}) && (edges_w != 5'h00);
                    phase_o <= phase_reg;
                end else begin
                    tick_reg <= tick_reg + 12'h001;
                    edge_reg <= edges_w;
                end
            end
        end
    end
endmodule

// File: tb/rfsm_asserts.sv
module rfsm_asserts (
    // Clock and reset
    input logic clk_i,
    input logic srst_i,
    // Pins and analog levels
    input logic ss_i,
    input logic mosi_i,
    input logic sclk_i,
    input logic am_sub_i,
    input logic pm_sub_i,
    input logic ext_field_i,
    // Commands and configuration
    input logic cmd_transparent_i,
    input logic cmd_any_i,
    input logic cmd_transmit_i,
    input logic rx_am_en_i,
    input logic rx_pm_en_i,
    input logic external_field_detect_enable_i,
    input logic [7:0] op_ctrl_i,
    input logic stream_en_i,
    // Watched outputs
    input logic miso_o,
    input logic miso_oe_n_o,
    input logic irq_pin_o,
    input logic mod_on_o,
    input logic rx_on_o,
    input logic transparent_o,
    input logic low_power_target_o,
    input logic field_on_evt_o,
    input logic tx_busy_o,
    input logic tx_end_evt_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    logic armed_reg;
    // Remembers a transparent command not yet used or cancelled
    always @(posedge clk_i) begin
        if (srst_i) armed_reg <= 1'b0;
        else if (cmd_transparent_i) armed_reg <= 1'b1;
        else if (cmd_any_i || transparent_o) armed_reg <= 1'b0;
    end
    sequence s_tr_steady;
        transparent_o && $past(transparent_o);
    endsequence
    sequence s_lp_cfg;
        external_field_detect_enable_i && op_ctrl_i == 8'h00;
    endsequence
    sequence s_tx_req;
        cmd_transmit_i && stream_en_i && !tx_busy_o && !transparent_o;
    endsequence
    a_entry_needs_cmd: assert property ($rose(transparent_o) |-> armed_reg)
        else $error("transparent mode entered without command");
    a_exit_on_cs: assert property (!ss_i |-> ##[1:4] !transparent_o)
        else $error("transparent mode kept with chip-select low");
    a_exit_on_cmd: assert property (cmd_any_i |=> !transparent_o)
        else $error("transparent mode kept after a command");
    a_mod_follows_mosi: assert property (s_tr_steady |-> mod_on_o == $past(mosi_i, 3))
        else $error("modulator does not follow data-in pin");
    a_rx_follows_clk: assert property (s_tr_steady |-> rx_on_o == $past(sclk_i, 3))
        else $error("receiver enable does not follow clock pin");
    a_miso_route: assert property (s_tr_steady |-> miso_o == ($past(rx_am_en_i) ? $past(am_sub_i, 3) :
        $past(rx_pm_en_i) && $past(pm_sub_i, 3))) else $error("data-out pin carries wrong channel");
    a_irq_route: assert property (s_tr_steady |-> irq_pin_o == ($past(external_field_detect_enable_i) ?
        $past(ext_field_i, 3) : $past(rx_am_en_i) && $past(rx_pm_en_i) && $past(pm_sub_i, 3)))
        else $error("interrupt pin carries wrong signal");
    a_pin_idle: assert property (miso_oe_n_o != transparent_o && (transparent_o || !miso_o && !irq_pin_o))
        else $error("pins driven outside transparent mode");
    a_low_power: assert property (s_lp_cfg ##1 s_lp_cfg |-> low_power_target_o)
        else $error("low-power target state not entered");
    a_field_event: assert property (low_power_target_o && $rose(ext_field_i) |-> ##[1:6] field_on_evt_o)
        else $error("field-on event missing");
    a_tx_start: assert property (s_tx_req |=> tx_busy_o)
        else $error("transmit command not taken");
    a_tx_end: assert property (tx_end_evt_o |-> !tx_busy_o && $past(tx_busy_o))
        else $error("transmit end without busy drop");
endmodule
bind rfsm_top rfsm_asserts chk (.clk_i, .srst_i, .ss_i, .mosi_i, .sclk_i, .am_sub_i, .pm_sub_i, .ext_field_i,
    .cmd_transparent_i, .cmd_any_i, .cmd_transmit_i, .rx_am_en_i, .rx_pm_en_i, .external_field_detect_enable_i,
    .op_ctrl_i, .stream_en_i, .miso_o, .miso_oe_n_o, .irq_pin_o, .mod_on_o, .rx_on_o, .transparent_o,
    .low_power_target_o, .field_on_evt_o, .tx_busy_o, .tx_end_evt_o);

// File: tb/rfsm_mcu_model.sv
module rfsm_mcu_model (
    // Clock
    input logic clk_i,
    // Pins and decoded commands toward the device
    output logic ss_o,
    output logic mosi_o,
    output logic sclk_o,
    output logic cmd_transparent_o,
    output logic cmd_any_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ss_o = 1'b1;
        mosi_o = 1'b0;
        sclk_o = 1'b0;
        cmd_transparent_o = 1'b0;
        cmd_any_o = 1'b0;
    end
    // Frame bits while selected carry no meaning for the mode logic
    always @(posedge clk_i) begin
        if (!ss_o) mosi_o <= ~mosi_o;
    end
    // Front end is set up by the caller before any command
    task automatic command(input logic transparent);
        @(posedge clk_i);
        #1;
        ss_o = 1'b0;
        // Command decodes inside the frame, after the synchroniser has seen select low
        @(posedge clk_i);
        #1;
        cmd_any_o = 1'b1;
        cmd_transparent_o = transparent;
        @(posedge clk_i);
        #1;
        cmd_any_o = 1'b0;
        cmd_transparent_o = 1'b0;
        @(posedge clk_i);
        #1;
        ss_o = 1'b1;
    endtask
    task automatic cs(input logic level);
        @(posedge clk_i);
        #1;
        ss_o = level;
    endtask
    task automatic pins(input logic mod, input logic rx);
        @(posedge clk_i);
        #1;
        mosi_o = mod;
        sclk_o = rx;
    endtask
endmodule

// File: tb/tb_rf_raw_stream_transparent_modes.sv
module tb_rf_raw_stream_transparent_modes;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic fc_tick_i, cmd_transmit_i, rx_am_en_i, rx_pm_en_i, external_field_detect_enable_i, stream_en_i;
    logic stream_kind_i, am_sub_i, pm_sub_i, ext_field_i, tx_avail_i;
    logic [7:0] op_ctrl_i, tx_byte_i;
    logic [1:0] scf_i;
    logic [2:0] scp_i, stx_i;
    wire ss_i, mosi_i, sclk_i, cmd_transparent_i, cmd_any_i, miso_o, miso_oe_n_o, irq_pin_o, mod_on_o, rx_on_o;
    wire rx_byte_valid_o, tx_pop_o, transparent_o, low_power_target_o, field_on_evt_o, rx_start_evt_o;
    wire rx_end_evt_o, tx_busy_o, tx_end_evt_o;
    wire [7:0] rx_byte_o;
    wire [3:0] rx_byte_bits_o;
    int mismatches = 0, n_compared = 0, cycles = 0, n_start = 0, n_end = 0, n_field = 0, k, tl;
    logic [31:0] seed = 32'h0000572b, r;
    logic [11:0] got[$], exp_q[$];
    rfsm_top uut (.clk_i, .srst_i, .fc_tick_i, .ss_i, .mosi_i, .sclk_i, .miso_o, .miso_oe_n_o, .irq_pin_o,
        .cmd_transparent_i, .cmd_any_i, .cmd_transmit_i, .rx_am_en_i, .rx_pm_en_i, .external_field_detect_enable_i,
        .op_ctrl_i, .stream_en_i, .stream_kind_i, .scf_i, .scp_i, .stx_i, .am_sub_i, .pm_sub_i, .ext_field_i,
        .mod_on_o, .rx_on_o, .rx_byte_o, .rx_byte_valid_o, .rx_byte_bits_o, .tx_byte_i, .tx_avail_i, .tx_pop_o,
        .transparent_o, .low_power_target_o, .field_on_evt_o, .rx_start_evt_o, .rx_end_evt_o, .tx_busy_o,
        .tx_end_evt_o);
    rfsm_mcu_model mcu (.clk_i, .ss_o(ss_i), .mosi_o(mosi_i), .sclk_o(sclk_i), .cmd_transparent_o(cmd_transparent_i),
        .cmd_any_o(cmd_any_i));
    always #10 clk_i = ~clk_i;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
        n_compared++;
        if (seen !== expd) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (rx_byte_valid_o) got.push_back({rx_byte_bits_o, rx_byte_o});
        n_start += rx_start_evt_o;
        n_end += rx_end_evt_o;
        n_field += field_on_evt_o;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    // Drives whole reporting periods; the model packs the expected bytes
    task automatic rx_run(input logic kind, input int per, input int sc, input int nb, input int tail);
        logic [7:0] e;
        int lv, n;
        int bits[$];
        r = rnd() | 32'h1;
        got.delete();
        exp_q.delete();
        {n_start, n_end} = 0;
        stream_kind_i = kind;
        stream_en_i = 1'b1;
        tick(4);
        for (int p = 0; p < nb + tail; p++) begin
            for (int t = 0; t < per; t++) begin
                // Periods start two ticks late to line up with the pin synchroniser
                fc_tick_i = p * per + t > 1;
                if (p >= nb) lv = 0;
                else if (kind) lv = ((t + 3) % sc < sc / 2) ^ r[p];
                else lv = r[p] && t >= 8 && t < per - 8 && (t - 8) % sc < sc / 2;
                {am_sub_i, pm_sub_i} = {2{lv[0]}};
                tick(1);
            end
        end
        for (int p = 0; p < nb; p++) bits.push_back(kind ? r[p] ^ r[0] : r[p]);
        // Trailing empty data periods already count toward the end gap
        while (!kind && bits[$] == 0) void'(bits.pop_back());
        if (!kind) repeat (8) bits.push_back(0);
        while (bits.size() > 0) begin
            e = 8'h00;
            for (n = 0; n < 8 && bits.size() > 0; n++) e[n] = bits.pop_front();
            exp_q.push_back({n[3:0], e});
        end
        chk(got.size(), exp_q.size());
        for (int i = 0; i < got.size() && i < exp_q.size(); i++) chk(got[i], exp_q[i]);
        chk(n_start, 1);
        chk(n_end, 1);
        {stream_en_i, fc_tick_i} = 2'h0;
        tick(2);
        $display("stream receive kind %0d done", kind);
    endtask
    initial begin
        {fc_tick_i, cmd_transmit_i, rx_am_en_i, rx_pm_en_i, external_field_detect_enable_i} = 5'h06;
        {stream_en_i, stream_kind_i, am_sub_i, pm_sub_i, ext_field_i, tx_avail_i} = 6'h00;
        {op_ctrl_i, tx_byte_i, scf_i, scp_i, stx_i} = {8'h80, 8'h00, 2'h1, 3'h0, 3'h3};
        repeat (16) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
        tick(2);
        chk({transparent_o, miso_oe_n_o, miso_o, irq_pin_o, mod_on_o, tx_busy_o, low_power_target_o}, 7'h20);
        mcu.cs(1'b0);
        mcu.cs(1'b1);
        tick(6);
        chk(transparent_o, 1'b0);
        mcu.command(1'b1);
        tick(5);
        chk({transparent_o, miso_oe_n_o}, 2'h2);
        for (k = 1; k < 8; k++) begin
            if (k == 4) continue;
            {external_field_detect_enable_i, rx_pm_en_i, rx_am_en_i} = k[2:0];
            r = rnd();
            {ext_field_i, pm_sub_i, am_sub_i} = r[2:0];
            mcu.pins(r[3], r[4]);
            tick(4);
            chk({rx_on_o, mod_on_o}, r[4:3]);
            chk(miso_o, k[0] ? r[0] : r[1]);
            chk(irq_pin_o, k[2] ? r[2] : k[1] && k[0] && r[1]);
        end
        mcu.cs(1'b0);
        tick(5);
        chk({transparent_o, miso_oe_n_o}, 2'h1);
        mcu.cs(1'b1);
        mcu.command(1'b1);
        tick(5);
        chk(transparent_o, 1'b1);
        mcu.command(1'b0);
        tick(5);
        chk(transparent_o, 1'b0);
        $display("transparent test done");
        {external_field_detect_enable_i, op_ctrl_i, ext_field_i, n_field} = {1'b1, 8'h00, 1'b0, 32'h0};
        tick(4);
        chk(low_power_target_o, 1'b1);
        ext_field_i = 1'b1;
        tick(8);
        chk(n_field, 1);
        op_ctrl_i = rnd() | 8'h80;
        tick(4);
        chk(low_power_target_o, 1'b0);
        {external_field_detect_enable_i, ext_field_i, rx_am_en_i, rx_pm_en_i} = 4'h3;
        $display("low-power target test done");
        scp_i = 3'h2;
        rx_run(1'b0, 128, 32, 5, 12);
        scp_i = 3'h1;
        rx_run(1'b1, 16, 8, 11, 3);
        {scf_i, scp_i} = {2'(rnd() % 3), 3'(rnd())};
        rx_run(1'b0, (64 >> scf_i) * (scp_i > 6 ? 8 : scp_i + 2), 64 >> scf_i, 6, 12);
        {tx_byte_i, tx_avail_i, stream_en_i, fc_tick_i} = {8'(rnd()), 3'h7};
        stx_i = 3'(rnd() % 3) + 3'h2;
        tl = 128 >> stx_i;
        tick(2);
        cmd_transmit_i = 1'b1;
        tick(1);
        cmd_transmit_i = 1'b0;
        for (k = 0; k < 8 && !tx_pop_o; k++) tick(1);
        chk(tx_pop_o, 1'b1);
        tx_avail_i = 1'b0;
        tick(tl / 2);
        for (k = 0; k < 8; k++) begin
            chk(mod_on_o, tx_byte_i[k]);
            if (k < 7) tick(tl);
        end
        for (k = 0; k < 200 && !tx_end_evt_o; k++) tick(1);
        chk({tx_end_evt_o, tx_busy_o}, 2'h2);
        $display("stream transmit test done");
        close_out();
    end
endmodule
